// file: cvt_pkg.sv
/*
  Constants, register indices and types of the calibration-vector and trim register bank.
  Assumes a 32-bit AXI4-Lite slave where each register index occupies one word (byte = 4*index).
*/
package cvt_pkg;
  // AXI4-Lite shape
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_EN = 8'h70;
  localparam logic [7:0] IDX_VECTOR = 8'h71;
  localparam logic [7:0] IDX_GAIN_A = 8'h7A;
  localparam logic [7:0] IDX_GAIN_B = 8'h7B;
  localparam logic [7:0] IDX_BANDGAP = 8'h7C;
  localparam logic [7:0] IDX_TERM_A = 8'h7E;
  localparam logic [7:0] IDX_TERM_B = 8'h7F;
  localparam logic [7:0] IDX_STATUS = 8'h80;
  localparam logic [7:0] IDX_STREAM = 8'h81;
  localparam logic [7:0] IDX_ALIAS_LO = 8'h72;
  localparam logic [7:0] IDX_ALIAS_HI = 8'h79;

  // Field positions
  localparam int PORT_EN_BIT = 0;
  localparam int HOLD_BIT = 0;
  localparam int ST_HALTED_BIT = 0;
  localparam int ST_COMPLETE_BIT = 1;
  localparam int ST_FIFO_EMPTY_BIT = 2;
  localparam int BANDGAP_ADJUST_MSB = 3;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_INDEX = 10'h000;

  // Calibration vector length
  localparam logic [9:0] VECTOR_LAST = 10'h2A0;
  localparam logic [9:0] INDEX_STEP = 10'h001;
  localparam int INDEX_W = 10;

  // Write buffer
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 18;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_DRAIN = 2'b01,
    RD_FETCH = 2'b10,
    RD_RESP = 2'b11
  } cvt_rd_state_t;
endpackage

// file: cvt_fifo.sv
/*
  Synchronous FIFO with a registered output stage, used to buffer restore bytes.
  Assumes one clock; the drain side may stall via out_ready_i at any time.
*/
`timescale 1ns/1ps
module cvt_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic empty_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != DEPTH[PW:0]);
  assign push = in_valid_i && in_ready_o;
  // Refill the output stage whenever it is free or being taken
  assign pop = (count != '0) && (!out_valid_o || out_ready_i);
  assign empty_o = (count == '0) && !out_valid_o;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o <= mem[rd_ptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_fifo_no_overflow: assert property (count == DEPTH[PW:0] |-> !in_ready_o)
    else $error("fifo accepts data while full");
endmodule

// file: cvt_calib_regs.sv
/*
  Calibration-vector save/restore port and fuse-initialised trim registers behind AXI4-Lite.
  Assumes the calibration engine serves byte reads by index and accepts indexed restore bytes,
  and that fuse values are stable at reset release.
*/
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - With port enabled, each vector port read returns the next stored calibration byte.
// - Restore is 673 writes; each byte goes to the next store position.
// - With address hold set, incrementing streaming accesses up to IDX_ALIAS_HI keep hitting the vector port.
// - Trims load factory fuse values after reset, readable and overwritable.
// - Gain trim A, 8 bits, fuse default, drives input A gain.
// - Gain trim B, 8 bits, fuse default, drives input B gain.
// - Band-gap trim in bits 3:0, upper bits reserved, fuse default.
// - Termination trim A, 8 bits, fuse default, drives input A termination.
// - Termination trim B, fuse default, drives input B termination.
// - Bit 0 of the enable register gates all vector port access.
module cvt_calib_regs
  import cvt_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic calib_halted_flag_i,
  output logic cal_port_en_o,
  output logic addr_hold_o,
  output logic [INDEX_W-1:0] cal_index_o,
  output logic cal_rd_req_o,
  input wire logic [7:0] cal_rd_data_i,
  input wire logic cal_rd_valid_i,
  output logic cal_wr_valid_o,
  output logic [7:0] cal_wr_data_o,
  output logic [INDEX_W-1:0] cal_wr_index_o,
  input wire logic cal_wr_ready_i,
  input wire logic [7:0] fuse_gain_a_i,
  input wire logic [7:0] fuse_gain_b_i,
  input wire logic [3:0] fuse_bandgap_i,
  input wire logic [7:0] fuse_term_a_i,
  input wire logic [7:0] fuse_term_b_i,
  output logic [7:0] gain_adjust_a_o,
  output logic [7:0] gain_adjust_b_o,
  output logic [3:0] bandgap_adjust_o,
  output logic [7:0] termination_adjust_a_o,
  output logic [7:0] termination_adjust_b_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  cvt_rd_state_t rd_state;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte, bandgap_adjust, wr_idx, rd_idx;
  logic [FIFO_W-1:0] fifo_out;
  logic aw_got, w_got, w_lane0, fuse_loaded, vector_complete, fifo_in_ready, fifo_empty;
  logic wr_is_vec, rd_is_vec, wr_pending, wr_vec_take, wr_stall, wr_commit, wr_reg;
  logic push, rd_advance, advance, en_rise, ar_hs;
  function automatic logic is_vec(input logic [ADDR_W-1:0] a, input logic hold);
    logic [7:0] i;
    i = a[9:2];
    return (a[11:10] == 2'h0) && ((i == IDX_VECTOR) ||
           (hold && (i >= IDX_ALIAS_LO) && (i <= IDX_ALIAS_HI)));
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a, input logic hold);
    logic [7:0] i;
    i = a[9:2];
    return is_vec(a, hold) || ((a[11:10] == 2'h0) &&
           ((i == IDX_PORT_EN) || (i == IDX_GAIN_A) || (i == IDX_GAIN_B) ||
            (i == IDX_BANDGAP) || (i == IDX_TERM_A) || (i == IDX_TERM_B) ||
            (i == IDX_STATUS) || (i == IDX_STREAM)));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel capture

  assign wr_idx = aw_addr[9:2];
  assign rd_idx = s_axi_araddr_i[9:2];
  assign wr_is_vec = is_vec(aw_addr, addr_hold_o);
  assign rd_is_vec = is_vec(s_axi_araddr_i, addr_hold_o);
  assign wr_pending = aw_got && w_got && !s_axi_bvalid_o;
  // Disabled port swallows the write
  assign wr_vec_take = wr_pending && wr_is_vec && cal_port_en_o && w_lane0;
  // Hold the response rather than drop a byte; full buffer back-pressures the bus
  assign wr_stall = wr_vec_take && (!fifo_in_ready || rd_state == RD_FETCH);
  assign wr_commit = wr_pending && !wr_stall;
  // Upper address bits set: answered with an error, no register may change
  assign wr_reg = wr_commit && w_lane0 && !wr_is_vec && (aw_addr[11:10] == 2'h0);
  assign push = wr_vec_take && !wr_stall;
  assign rd_advance = (rd_state == RD_FETCH) && cal_rd_valid_i;
  assign advance = push || rd_advance;
  assign en_rise = wr_reg && (wr_idx == IDX_PORT_EN) && w_byte[PORT_EN_BIT] && !cal_port_en_o;
  assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_got <= 1'b0;
      s_axi_awready_o <= 1'b1;
      aw_addr <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_got <= 1'b1;
      s_axi_awready_o <= 1'b0;
      aw_addr <= s_axi_awaddr_i;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      aw_got <= 1'b0;
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w_got <= 1'b0;
      s_axi_wready_o <= 1'b1;
      w_byte <= RST_BYTE;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_got <= 1'b1;
      s_axi_wready_o <= 1'b0;
      w_byte <= s_axi_wdata_i[7:0];
      w_lane0 <= s_axi_wstrb_i[0];
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      w_got <= 1'b0;
      s_axi_wready_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= is_mapped(aw_addr, addr_hold_o) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control and trim registers

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cal_port_en_o <= 1'b0;
      addr_hold_o <= 1'b0;
    end else if (wr_reg) begin
      if (wr_idx == IDX_PORT_EN) begin
        cal_port_en_o <= w_byte[PORT_EN_BIT];
      end
      if (wr_idx == IDX_STREAM) begin
        addr_hold_o <= w_byte[HOLD_BIT];
      end
    end
  end

  // Fuses are caught one edge after reset release, never by the reset itself
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fuse_loaded <= 1'b0;
      gain_adjust_a_o <= RST_BYTE;
      gain_adjust_b_o <= RST_BYTE;
      bandgap_adjust <= RST_BYTE;
      termination_adjust_a_o <= RST_BYTE;
      termination_adjust_b_o <= RST_BYTE;
    end else if (!fuse_loaded) begin
      fuse_loaded <= 1'b1;
      gain_adjust_a_o <= fuse_gain_a_i;
      gain_adjust_b_o <= fuse_gain_b_i;
      bandgap_adjust <= {4'h0, fuse_bandgap_i};
      termination_adjust_a_o <= fuse_term_a_i;
      termination_adjust_b_o <= fuse_term_b_i;
    end else if (wr_reg) begin
      unique case (wr_idx)
        IDX_GAIN_A: gain_adjust_a_o <= w_byte;
        IDX_GAIN_B: gain_adjust_b_o <= w_byte;
        IDX_BANDGAP: bandgap_adjust <= w_byte;
        IDX_TERM_A: termination_adjust_a_o <= w_byte;
        IDX_TERM_B: termination_adjust_b_o <= w_byte;
        default: ;
      endcase
    end
  end

  // Reserved upper bits are stored but steer nothing
  assign bandgap_adjust_o = bandgap_adjust[BANDGAP_ADJUST_MSB:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Vector byte index

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cal_index_o <= RST_INDEX;
    end else if (en_rise) begin
      cal_index_o <= RST_INDEX;
    end else if (advance) begin
      cal_index_o <= (cal_index_o == VECTOR_LAST) ? RST_INDEX :
                     cal_index_o + INDEX_STEP;
    end
  end

  // Set on the last byte wins over the clear on a fresh enable
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vector_complete <= 1'b0;
    end else if (advance && cal_index_o == VECTOR_LAST) begin
      vector_complete <= 1'b1;
    end else if (en_rise || (advance && cal_index_o == RST_INDEX)) begin
      vector_complete <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel

  function automatic logic [7:0] reg_value(input logic [7:0] i);
    unique case (i)
      IDX_PORT_EN: reg_value = {7'h00, cal_port_en_o};
      IDX_GAIN_A: reg_value = gain_adjust_a_o;
      IDX_GAIN_B: reg_value = gain_adjust_b_o;
      IDX_BANDGAP: reg_value = bandgap_adjust;
      IDX_TERM_A: reg_value = termination_adjust_a_o;
      IDX_TERM_B: reg_value = termination_adjust_b_o;
      IDX_STATUS: reg_value = {5'h00, fifo_empty, vector_complete, calib_halted_flag_i};
      IDX_STREAM: reg_value = {7'h00, addr_hold_o};
      default: reg_value = RST_BYTE;
    endcase
  endfunction

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_state <= RD_IDLE;
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
      cal_rd_req_o <= 1'b0;
    end else begin
      cal_rd_req_o <= 1'b0;
      unique case (rd_state)
        RD_IDLE: begin
          if (ar_hs) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rresp_o <= is_mapped(s_axi_araddr_i, addr_hold_o) ? RESP_OKAY : RESP_SLVERR;
            if (rd_is_vec && cal_port_en_o) begin
              rd_state <= RD_DRAIN;
            end else begin
              // Disabled port and unmapped addresses read as zero
              s_axi_rdata_o <= (rd_is_vec || s_axi_araddr_i[11:10] != 2'h0) ? '0 :
                               {24'h000000, reg_value(rd_idx)};
              s_axi_rvalid_o <= 1'b1;
              rd_state <= RD_RESP;
            end
          end
        end
        RD_DRAIN: begin
          // Pending restore bytes land first so the index stays in order
          if (fifo_empty && !push) begin
            cal_rd_req_o <= 1'b1;
            rd_state <= RD_FETCH;
          end
        end
        RD_FETCH: begin
          if (cal_rd_valid_i) begin
            s_axi_rdata_o <= {24'h000000, cal_rd_data_i};
            s_axi_rvalid_o <= 1'b1;
            rd_state <= RD_RESP;
          end
        end
        RD_RESP: begin
          if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
            rd_state <= RD_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Restore buffer toward the calibration engine

  cvt_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_restore_fifo (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({cal_index_o, w_byte}),
    .out_valid_o(cal_wr_valid_o),
    .out_ready_i(cal_wr_ready_i),
    .out_data_o(fifo_out),
    .empty_o(fifo_empty)
  );

  assign cal_wr_data_o = fifo_out[7:0];
  assign cal_wr_index_o = fifo_out[FIFO_W-1:8];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_vec_ar;
    ar_hs && rd_is_vec && cal_port_en_o && rd_state == RD_IDLE;
  endsequence
  sequence s_fetch_done;
    rd_state == RD_FETCH && cal_rd_valid_i;
  endsequence
  a_vec_read_data: assert property (s_fetch_done |=> s_axi_rvalid_o &&
      s_axi_rdata_o == {24'h000000, $past(cal_rd_data_i)})
    else $error("vector read data not returned");
  // Fetch waits for the restore buffer, which the engine may stall at will
  a_vec_read_step: assert property (s_vec_ar ##1 (fifo_empty && !push) |=>
      cal_rd_req_o && rd_state == RD_FETCH)
    else $error("vector read never fetched");
  a_write_index_step: assert property (push && !en_rise && cal_index_o != VECTOR_LAST |=>
      cal_index_o == $past(cal_index_o) + INDEX_STEP)
    else $error("restore index did not step");
  a_hold_alias_read: assert property (ar_hs && rd_state == RD_IDLE && addr_hold_o &&
      cal_port_en_o && rd_idx == IDX_ALIAS_LO |=> rd_state == RD_DRAIN)
    else $error("held address not routed to vector port");
  a_complete_flag: assert property (advance && cal_index_o == VECTOR_LAST |=>
      vector_complete && cal_index_o == RST_INDEX)
    else $error("vector completion not flagged");
  a_fuse_load: assert property ($rose(fuse_loaded) |->
      gain_adjust_a_o == $past(fuse_gain_a_i) && termination_adjust_b_o == $past(fuse_term_b_i))
    else $error("fuse defaults not loaded");
  a_gain_write: assert property (fuse_loaded && wr_reg &&
      wr_idx == IDX_GAIN_A |=> gain_adjust_a_o == $past(w_byte))
    else $error("gain trim write lost");
  a_bandgap_write: assert property (fuse_loaded && wr_reg &&
      wr_idx == IDX_BANDGAP |=> bandgap_adjust_o == $past(w_byte[3:0]))
    else $error("band-gap trim write lost");
  a_disabled_read: assert property (ar_hs && rd_state == RD_IDLE && rd_is_vec &&
      !cal_port_en_o |=> s_axi_rvalid_o && s_axi_rdata_o == '0)
    else $error("disabled vector port returned data");
  a_index_restart: assert property (en_rise |=> cal_index_o == RST_INDEX && cal_port_en_o)
    else $error("index not restarted on enable");
  a_full_stall: assert property (wr_vec_take && !fifo_in_ready |=> !s_axi_bvalid_o)
    else $error("write answered while buffer full");
endmodule

// file: cvt_calib_regs_test.sv
/*
  Self-checking bench of the calibration-vector and trim register bank.
  Assumes cvt_pkg, cvt_fifo and cvt_calib_regs are compiled first; the bench stands in for
  the calibration engine and the fuse block.
*/
`timescale 1ns/1ps
module cvt_calib_regs_test;
  import cvt_pkg::*;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
  logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic calib_halted_flag_i = 1'b1;
  logic [7:0] cal_rd_data_i = 8'h00;
  logic cal_rd_valid_i = 1'b0, cal_wr_ready_i = 1'b0;
  logic [7:0] fuse_gain_a_i = 8'h00, fuse_gain_b_i = 8'h00;
  logic [7:0] fuse_term_a_i = 8'h00, fuse_term_b_i = 8'h00;
  logic [3:0] fuse_bandgap_i = 4'h0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic cal_port_en_o, addr_hold_o, cal_rd_req_o, cal_wr_valid_o;
  logic [9:0] cal_index_o, cal_wr_index_o, eng_idx;
  logic [7:0] cal_wr_data_o, gain_adjust_a_o, gain_adjust_b_o;
  logic [7:0] termination_adjust_a_o, termination_adjust_b_o, nv, d;
  logic [3:0] bandgap_adjust_o;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [17:0] wq[$];
  logic [11:0] taddr[5] = '{12'h1E8, 12'h1EC, 12'h1F0, 12'h1F8, 12'h1FC};
  logic [7:0] texp[5];
  logic stall = 1'b1;
  int failures = 0, checked = 0;
  int dly = -1, n;

  cvt_calib_regs dut (.mclk_i, .arst_n_i, .s_axi_awaddr_i, .s_axi_awprot_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arprot_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .calib_halted_flag_i, .cal_port_en_o, .addr_hold_o, .cal_index_o,
    .cal_rd_req_o, .cal_rd_data_i, .cal_rd_valid_i, .cal_wr_valid_o, .cal_wr_data_o,
    .cal_wr_index_o, .cal_wr_ready_i, .fuse_gain_a_i, .fuse_gain_b_i, .fuse_bandgap_i,
    .fuse_term_a_i, .fuse_term_b_i, .gain_adjust_a_o, .gain_adjust_b_o, .bandgap_adjust_o,
    .termination_adjust_a_o, .termination_adjust_b_o);

  always #2 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input logic [9:0] i);
    return i[7:0] ^ {i[9:8], 6'h2D};
  endfunction

  function automatic logic [7:0] trim_out(input int k);
    case (k)
      0: return gain_adjust_a_o;
      1: return gain_adjust_b_o;
      2: return {4'h0, bandgap_adjust_o};
      3: return termination_adjust_a_o;
      default: return termination_adjust_b_o;
    endcase
  endfunction

  task automatic test_done();
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string m, input logic [33:0] g, input logic [33:0] e);
    checked++;
    if (g !== e || $isunknown(g)) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic cmp_rd(input logic [33:0] g);
    check("read", g, (rq.size() > 0) ? rq.pop_front() : ~g);
  endtask

  task automatic cmp_b(input logic [1:0] g);
    check("bresp", {32'h0, g}, (bq.size() > 0) ? {32'h0, bq.pop_front()} : {32'h0, ~g});
  endtask

  task automatic cmp_wr(input logic [17:0] g);
    check("restore", {16'h0, g}, (wq.size() > 0) ? {16'h0, wq.pop_front()} : {16'h0, ~g});
  endtask

  task automatic cmp_out(input logic [9:0] g, input logic [9:0] e);
    check("output", {24'h0, g}, {24'h0, e});
  endtask

  // Bounded step: a hung handshake ends the run as a failure
  task automatic tick(inout int c);
    @(posedge mclk_i);
    c++;
    if (c > 3000) begin
      failures++;
      $display("MISMATCH %0t handshake timeout", $time);
      test_done();
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
    int c = 0;
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    bq.push_back(er);
    @(posedge mclk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, v};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      tick(c);
      if (!aw_ok && s_axi_awready_o) begin
        aw_ok = 1'b1;
        s_axi_awvalid_i <= 1'b0;
      end
      if (!w_ok && s_axi_wready_o) begin
        w_ok = 1'b1;
        s_axi_wvalid_i <= 1'b0;
      end
    end
    do tick(c); while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [7:0] ev, input logic [1:0] er);
    int c = 0;
    rq.push_back({er, 24'h0, ev});
    @(posedge mclk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do tick(c); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    do tick(c); while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Engine stand-in: answers fetches after 0..3 cycles, junk on the data lines otherwise
  always @(posedge mclk_i) begin
    if (cal_rd_req_o) begin
      dly = $urandom_range(0, 3);
      eng_idx = cal_index_o;
    end
    if (dly == 0) begin
      cal_rd_valid_i <= 1'b1;
      cal_rd_data_i <= pat(eng_idx);
    end else begin
      cal_rd_valid_i <= 1'b0;
      cal_rd_data_i <= ~cal_rd_data_i;
    end
    if (dly >= 0) dly--;
    cal_wr_ready_i <= stall ? 1'b0 : 1'($urandom_range(0, 1));
  end

  always @(posedge mclk_i) begin
    if (s_axi_rvalid_o && s_axi_rready_i) cmp_rd({s_axi_rresp_o, s_axi_rdata_o});
    if (s_axi_bvalid_o && s_axi_bready_i) cmp_b(s_axi_bresp_o);
    if (cal_wr_valid_o && cal_wr_ready_i) cmp_wr({cal_wr_index_o, cal_wr_data_o});
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h32DA3408));
    {fuse_gain_a_i, fuse_gain_b_i, fuse_term_a_i, fuse_term_b_i} = $urandom;
    fuse_bandgap_i = 4'($urandom);
    texp = '{fuse_gain_a_i, fuse_gain_b_i, {4'h0, fuse_bandgap_i}, fuse_term_a_i, fuse_term_b_i};
    repeat (12) @(posedge mclk_i);
    cmp_out({2'h0, gain_adjust_a_o}, 10'h000);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    for (int k = 0; k < 5; k++) begin
      cmp_out({2'h0, trim_out(k)}, {2'h0, texp[k]});
      axi_read(taddr[k], texp[k], RESP_OKAY);
      nv = 8'($urandom);
      axi_write(taddr[k], nv, RESP_OKAY);
      axi_read(taddr[k], nv, RESP_OKAY);
      cmp_out({2'h0, trim_out(k)}, {2'h0, (k == 2) ? {4'h0, nv[3:0]} : nv});
    end
    axi_read(12'h300, 8'h00, RESP_SLVERR);
    // Upper address bits set: no trim may take the write
    axi_write(12'hDFC, ~nv, RESP_SLVERR);
    axi_read(12'hDFC, 8'h00, RESP_SLVERR);
    cmp_out({2'h0, termination_adjust_b_o}, {2'h0, nv});
    axi_read(12'h1C4, 8'h00, RESP_OKAY);
    axi_write(12'h1C4, 8'h5A, RESP_OKAY);
    axi_write(12'h1C8, 8'h11, RESP_SLVERR);
    cmp_out(cal_index_o, 10'h000);
    axi_write(12'h1C0, 8'h01, RESP_OKAY);
    axi_write(12'h204, 8'h01, RESP_OKAY);
    cmp_out({8'h0, cal_port_en_o, addr_hold_o}, 10'h003);
    // Incrementing master walks the alias range yet stays on the vector port
    for (int i = 0; i < 673; i++) begin
      axi_read(12'h1C4 + 12'(4 * (i % 9)), pat(10'(i)), RESP_OKAY);
    end
    cmp_out(cal_index_o, 10'h000);
    axi_read(12'h200, 8'h07, RESP_OKAY);
    for (int i = 0; i < 5; i++) axi_read(12'h1C4, pat(10'(i)), RESP_OKAY);
    axi_write(12'h204, 8'h00, RESP_OKAY);
    axi_write(12'h1C0, 8'h00, RESP_OKAY);
    axi_write(12'h1C0, 8'h01, RESP_OKAY);
    axi_read(12'h200, 8'h05, RESP_OKAY);
    // Engine stalls at first so the buffer fills and holds off the writes
    fork
      for (int i = 0; i < 673; i++) begin
        d = 8'($urandom);
        wq.push_back({10'(i), d});
        axi_write(12'h1C4, d, RESP_OKAY);
      end
      begin
        repeat (200) @(posedge mclk_i);
        stall <= 1'b0;
      end
    join
    n = 0;
    while (wq.size() > 0) tick(n);
    repeat (4) @(posedge mclk_i);
    axi_read(12'h200, 8'h07, RESP_OKAY);
    test_done();
  end
endmodule
